// *** lineout_pump_seq_pkg.sv ***
`default_nettype none
package lineout_pump_seq_pkg;

	// ****************************************
	// Register indices (byte address = 4 * index)
	// ****************************************
	localparam logic [7:0] IDX_LINEOUT = 8'h5e;
	localparam logic [7:0] IDX_PUMP = 8'h62;
	localparam logic [7:0] IDX_TRACK = 8'h68;
	localparam logic [7:0] IDX_SEQ_SETUP = 8'h6c;
	localparam logic [7:0] IDX_STEP_A = 8'h6d;
	localparam logic [7:0] IDX_STEP_B = 8'h6e;
	localparam logic [7:0] IDX_SEQ_RUN = 8'h6f;
	localparam logic [7:0] IDX_SEQ_STAT = 8'h70;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int LO_INPUT_BIT = 0;
	localparam int LO_MID_BIT = 1;
	localparam int LO_OUT_BIT = 2;
	localparam int PUMP_EN_BIT = 0;
	localparam int TRACK_BIT = 0;
	localparam int SEQ_EN_BIT = 8;
	localparam int SLOT_LSB = 0;
	localparam int STEP_WIDTH_LSB = 12;
	localparam int STEP_POS_LSB = 8;
	localparam int STEP_ADDR_LSB = 0;
	localparam int STEP_EOS_BIT = 14;
	localparam int STEP_DELAY_LSB = 8;
	localparam int STEP_DATA_LSB = 0;
	localparam int RUN_ABORT_BIT = 9;
	localparam int RUN_GO_BIT = 8;
	localparam int RUN_START_LSB = 0;
	localparam int STAT_CUR_LSB = 4;
	localparam int STAT_BUSY_BIT = 0;

	// ****************************************
	// Reset values and sizes
	// ****************************************
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int STEP_DEPTH = 32;
	localparam logic [5:0] LAST_RAM_SLOT = 6'h1f;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_UNIT_NS = 62500;
	localparam int UNIT_CYCLES = STEP_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [15:0] DELAY_BASE_UNITS = 16'h0008;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic eos;
		logic [3:0] delay;
		logic [7:0] data;
		logic [2:0] width;
		logic [3:0] pos;
		logic [7:0] addr;
	} step_t;

	typedef struct packed {
		logic en;
		logic [7:0] idx;
		logic [15:0] data;
		logic [15:0] mask;
	} reg_wr_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_EXEC,
		SEQ_WAIT
	} seq_state_t;

endpackage
`default_nettype wire

// *** lineout_pump_seq_ctrl_regs.sv ***
// Operation
// - Bit 0 input, bit 1 middle stage enable; one enables; both reset zero.
// - Pump register bit 0 enables charge pump control logic; reset zero.
// - Tracking bit zero selects volume-based pump supply; reset state.
// - Tracking bit one selects supply following real-time audio level.
// - Five-bit load slot at bits 4:0; step writes land in that slot.
// - Load slot reaches only writable step entries 0 to 31.
// - Step holds address, width code, LSB position, data, delay, end flag.
// - Go bit starts at start slot 0 to 31, runs to end flag or slot 31, then self-clears.
`timescale 1ns/1ps
`default_nettype none
module lineout_pump_seq_ctrl_regs #(
	parameter int UNIT_CYCLES = lineout_pump_seq_pkg::UNIT_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic right_line_input_stage_en_o,
	output logic right_line_mid_stage_en_o,
	output logic right_line_out_stage_en_o,
	output logic charge_pump_enable_o,
	output logic pump_level_tracking_o,
	output logic sequencer_enable_o,
	output logic sequencer_busy_o
);

	// ****************************************
	// Storage
	// ****************************************
	logic [2:0] lineout;
	logic pump_en, tracking, seq_en, go;
	logic [4:0] load_slot;
	logic [5:0] start_slot, cur_slot;
	lineout_pump_seq_pkg::step_t steps [lineout_pump_seq_pkg::STEP_DEPTH];
	lineout_pump_seq_pkg::seq_state_t state;
	logic [15:0] tick, units;
	logic access, aligned, bus_wr, go_req, abort_req, seq_done;
	logic [7:0] idx;
	lineout_pump_seq_pkg::step_t cur_step;
	lineout_pump_seq_pkg::reg_wr_t wr;

	// ****************************************
	// Decoding
	// ****************************************
	function automatic logic is_mapped(input logic [7:0] i);
		is_mapped = (i == lineout_pump_seq_pkg::IDX_LINEOUT) ||
			(i == lineout_pump_seq_pkg::IDX_PUMP) ||
			(i == lineout_pump_seq_pkg::IDX_TRACK) ||
			(i == lineout_pump_seq_pkg::IDX_SEQ_SETUP) ||
			(i == lineout_pump_seq_pkg::IDX_STEP_A) ||
			(i == lineout_pump_seq_pkg::IDX_STEP_B) ||
			(i == lineout_pump_seq_pkg::IDX_SEQ_RUN) ||
			(i == lineout_pump_seq_pkg::IDX_SEQ_STAT);
	endfunction
	// Masked field update shared by bus and sequencer writes
	function automatic logic merge(input logic old,
		input lineout_pump_seq_pkg::reg_wr_t w, input int bitpos);
		merge = w.mask[bitpos] ? w.data[bitpos] : old;
	endfunction
	assign access = psel_i && penable_i;
	assign idx = paddr_i[9:2];
	assign aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00);
	// Bus writes are locked out while a sequence runs, except abort
	assign bus_wr = access && pready_o && pwrite_i && aligned &&
		(!sequencer_busy_o || idx == lineout_pump_seq_pkg::IDX_SEQ_RUN);
	assign go_req = bus_wr && idx == lineout_pump_seq_pkg::IDX_SEQ_RUN &&
		pwdata_i[lineout_pump_seq_pkg::RUN_GO_BIT] && seq_en &&
		state == lineout_pump_seq_pkg::SEQ_IDLE;
	assign abort_req = (bus_wr &&
		idx == lineout_pump_seq_pkg::IDX_SEQ_RUN &&
		pwdata_i[lineout_pump_seq_pkg::RUN_ABORT_BIT]) || !seq_en;
	assign cur_step = steps[cur_slot[4:0]];

	// ****************************************
	// Write source select
	// ****************************************
	always_comb begin
		wr.en = 1'b0;
		wr.idx = idx;
		wr.data = pwdata_i[15:0];
		wr.mask = 16'hffff;
		if (state == lineout_pump_seq_pkg::SEQ_EXEC) begin
			// Step writes a width+1 bit field at its LSB position
			wr.en = 1'b1;
			wr.idx = cur_step.addr;
			wr.mask = 16'((17'h00002 << cur_step.width) - 17'h00001)
				<< cur_step.pos;
			wr.data = 16'({8'h00, cur_step.data} << cur_step.pos);
		end else if (bus_wr) begin
			wr.en = 1'b1;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lineout <= lineout_pump_seq_pkg::REG_RESET[2:0];
		end else if (wr.en && wr.idx == lineout_pump_seq_pkg::IDX_LINEOUT) begin
			lineout[0] <= merge(lineout[0], wr,
				lineout_pump_seq_pkg::LO_INPUT_BIT);
			lineout[1] <= merge(lineout[1], wr,
				lineout_pump_seq_pkg::LO_MID_BIT);
			lineout[2] <= merge(lineout[2], wr,
				lineout_pump_seq_pkg::LO_OUT_BIT);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pump_en <= lineout_pump_seq_pkg::REG_RESET[0];
		end else if (wr.en && wr.idx == lineout_pump_seq_pkg::IDX_PUMP) begin
			pump_en <= merge(pump_en, wr,
				lineout_pump_seq_pkg::PUMP_EN_BIT);
		end
	end

	// Zero means volume-based supply, one means level tracking
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tracking <= lineout_pump_seq_pkg::REG_RESET[0];
		end else if (wr.en && wr.idx == lineout_pump_seq_pkg::IDX_TRACK) begin
			tracking <= merge(tracking, wr,
				lineout_pump_seq_pkg::TRACK_BIT);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seq_en <= lineout_pump_seq_pkg::REG_RESET[0];
			load_slot <= lineout_pump_seq_pkg::REG_RESET[4:0];
		end else if (wr.en &&
			wr.idx == lineout_pump_seq_pkg::IDX_SEQ_SETUP) begin
			seq_en <= merge(seq_en, wr,
				lineout_pump_seq_pkg::SEQ_EN_BIT);
			// Five bits wide, so only slots 0 to 31 are reachable
			for (int b = 0; b < 5; b++) begin
				load_slot[b] <= merge(load_slot[b], wr,
					lineout_pump_seq_pkg::SLOT_LSB + b);
			end
		end
	end

	// ****************************************
	// Step memory
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < lineout_pump_seq_pkg::STEP_DEPTH; i++) begin
				steps[i] <= '0;
			end
		end else if (bus_wr && idx == lineout_pump_seq_pkg::IDX_STEP_A) begin
			steps[load_slot].width <=
				pwdata_i[lineout_pump_seq_pkg::STEP_WIDTH_LSB +: 3];
			steps[load_slot].pos <=
				pwdata_i[lineout_pump_seq_pkg::STEP_POS_LSB +: 4];
			steps[load_slot].addr <=
				pwdata_i[lineout_pump_seq_pkg::STEP_ADDR_LSB +: 8];
		end else if (bus_wr && idx == lineout_pump_seq_pkg::IDX_STEP_B) begin
			steps[load_slot].eos <=
				pwdata_i[lineout_pump_seq_pkg::STEP_EOS_BIT];
			steps[load_slot].delay <=
				pwdata_i[lineout_pump_seq_pkg::STEP_DELAY_LSB +: 4];
			steps[load_slot].data <=
				pwdata_i[lineout_pump_seq_pkg::STEP_DATA_LSB +: 8];
		end
	end

	// ****************************************
	// Sequencer run control
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			start_slot <= lineout_pump_seq_pkg::REG_RESET[5:0];
		end else if (bus_wr && idx == lineout_pump_seq_pkg::IDX_SEQ_RUN &&
			state == lineout_pump_seq_pkg::SEQ_IDLE) begin
			start_slot <= pwdata_i[lineout_pump_seq_pkg::RUN_START_LSB +: 6];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			go <= 1'b0;
		end else if (go_req) begin
			go <= 1'b1;
		end else if (seq_done) begin
			go <= 1'b0;
		end
	end

	// Slots above 31 hold no stored steps here, so such a run ends at once
	always_comb begin
		seq_done = 1'b0;
		if (go && state != lineout_pump_seq_pkg::SEQ_IDLE && abort_req) begin
			seq_done = 1'b1;
		end else if (state == lineout_pump_seq_pkg::SEQ_WAIT &&
			units == 16'h0001 && tick == 16'(UNIT_CYCLES - 1) &&
			(cur_step.eos || cur_slot == lineout_pump_seq_pkg::LAST_RAM_SLOT)) begin
			seq_done = 1'b1;
		end else if (go && state == lineout_pump_seq_pkg::SEQ_IDLE &&
			!go_req) begin
			seq_done = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= lineout_pump_seq_pkg::SEQ_IDLE;
			cur_slot <= 6'h00;
			tick <= 16'h0000;
			units <= 16'h0000;
		end else if (seq_done) begin
			state <= lineout_pump_seq_pkg::SEQ_IDLE;
		end else begin
			unique case (state)
				lineout_pump_seq_pkg::SEQ_IDLE: begin
					if (go_req && pwdata_i[5] == 1'b0) begin
						cur_slot <= pwdata_i[5:0];
						state <= lineout_pump_seq_pkg::SEQ_EXEC;
					end
				end
				lineout_pump_seq_pkg::SEQ_EXEC: begin
					// Step time counts its own execution cycle
					tick <= 16'h0001;
					units <= (16'h0001 << cur_step.delay) +
						lineout_pump_seq_pkg::DELAY_BASE_UNITS;
					state <= lineout_pump_seq_pkg::SEQ_WAIT;
				end
				lineout_pump_seq_pkg::SEQ_WAIT: begin
					if (tick == 16'(UNIT_CYCLES - 1)) begin
						tick <= 16'h0000;
						units <= units - 16'h0001;
						if (units == 16'h0001) begin
							cur_slot <= cur_slot + 6'h01;
							state <= lineout_pump_seq_pkg::SEQ_EXEC;
						end
					end else begin
						tick <= tick + 16'h0001;
					end
				end
			endcase
		end
	end

	// ****************************************
	// APB slave, one wait state
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= access && !pready_o;
			pslverr_o <= access && !pready_o && !(aligned && is_mapped(idx));
			prdata_o <= 32'h0000_0000;
			if (access && !pready_o && aligned && !pwrite_i) begin
				unique case (idx)
					lineout_pump_seq_pkg::IDX_LINEOUT:
						prdata_o[2:0] <= lineout;
					lineout_pump_seq_pkg::IDX_PUMP:
						prdata_o[lineout_pump_seq_pkg::PUMP_EN_BIT] <= pump_en;
					lineout_pump_seq_pkg::IDX_TRACK:
						prdata_o[lineout_pump_seq_pkg::TRACK_BIT] <= tracking;
					lineout_pump_seq_pkg::IDX_SEQ_SETUP: begin
						prdata_o[lineout_pump_seq_pkg::SEQ_EN_BIT] <= seq_en;
						prdata_o[lineout_pump_seq_pkg::SLOT_LSB +: 5] <= load_slot;
					end
					lineout_pump_seq_pkg::IDX_STEP_A: begin
						prdata_o[lineout_pump_seq_pkg::STEP_WIDTH_LSB +: 3] <=
							steps[load_slot].width;
						prdata_o[lineout_pump_seq_pkg::STEP_POS_LSB +: 4] <=
							steps[load_slot].pos;
						prdata_o[lineout_pump_seq_pkg::STEP_ADDR_LSB +: 8] <=
							steps[load_slot].addr;
					end
					lineout_pump_seq_pkg::IDX_STEP_B: begin
						prdata_o[lineout_pump_seq_pkg::STEP_EOS_BIT] <=
							steps[load_slot].eos;
						prdata_o[lineout_pump_seq_pkg::STEP_DELAY_LSB +: 4] <=
							steps[load_slot].delay;
						prdata_o[lineout_pump_seq_pkg::STEP_DATA_LSB +: 8] <=
							steps[load_slot].data;
					end
					lineout_pump_seq_pkg::IDX_SEQ_RUN: begin
						prdata_o[lineout_pump_seq_pkg::RUN_GO_BIT] <= go;
						prdata_o[lineout_pump_seq_pkg::RUN_START_LSB +: 6] <=
							start_slot;
					end
					lineout_pump_seq_pkg::IDX_SEQ_STAT: begin
						prdata_o[lineout_pump_seq_pkg::STAT_CUR_LSB +: 6] <=
							cur_slot;
						prdata_o[lineout_pump_seq_pkg::STAT_BUSY_BIT] <=
							sequencer_busy_o;
					end
					default: prdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			right_line_input_stage_en_o <= 1'b0;
			right_line_mid_stage_en_o <= 1'b0;
			right_line_out_stage_en_o <= 1'b0;
			charge_pump_enable_o <= 1'b0;
			pump_level_tracking_o <= 1'b0;
			sequencer_enable_o <= 1'b0;
			sequencer_busy_o <= 1'b0;
		end else begin
			right_line_input_stage_en_o <= lineout[0];
			right_line_mid_stage_en_o <= lineout[1];
			right_line_out_stage_en_o <= lineout[2];
			charge_pump_enable_o <= pump_en;
			pump_level_tracking_o <= tracking;
			sequencer_enable_o <= seq_en;
			sequencer_busy_o <= go_req ||
				(state != lineout_pump_seq_pkg::SEQ_IDLE && !seq_done);
		end
	end

endmodule
`default_nettype wire

// *** lineout_pump_seq_ctrl_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checks
// ****************************************
module lineout_pump_seq_ctrl_regs_checker #(
	parameter int UNIT_CYCLES = 4
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [11:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic right_line_input_stage_en_o,
	input wire logic right_line_mid_stage_en_o,
	input wire logic right_line_out_stage_en_o,
	input wire logic charge_pump_enable_o,
	input wire logic pump_level_tracking_o,
	input wire logic sequencer_enable_o,
	input wire logic sequencer_busy_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Idle only, since writes during a run are dropped, except those to the run register
	sequence s_wr(logic [7:0] idx);
		psel_i && penable_i && pready_o && pwrite_i && !sequencer_busy_o
			&& paddr_i == {2'b00, idx, 2'b00};
	endsequence
	sequence s_go;
		s_wr(lineout_pump_seq_pkg::IDX_SEQ_RUN) ##0
			(pwdata_i[8] && pwdata_i[5:0] < 6'h20 && sequencer_enable_o);
	endsequence
	property p_copy(logic [7:0] idx, int b, logic q);
		s_wr(idx) |-> ##2 q == $past(pwdata_i[b], 2);
	endproperty
	AST_READY_WAIT: assert property ($rose(psel_i && penable_i) |=> pready_o)
		else $error("pready late");
	AST_READY_PULSE: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	AST_READY_IN_ACCESS: assert property (pready_o |-> psel_i && penable_i)
		else $error("pready outside access");
	AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	AST_UPPER_ZERO: assert property (pready_o |-> prdata_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	AST_ERR_READ_ZERO: assert property (
		pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000)
		else $error("error read data not zero");
	AST_IN_STAGE: assert property (
		p_copy(lineout_pump_seq_pkg::IDX_LINEOUT,
			lineout_pump_seq_pkg::LO_INPUT_BIT, right_line_input_stage_en_o))
		else $error("input stage enable wrong");
	AST_MID_STAGE: assert property (
		p_copy(lineout_pump_seq_pkg::IDX_LINEOUT,
			lineout_pump_seq_pkg::LO_MID_BIT, right_line_mid_stage_en_o))
		else $error("mid stage enable wrong");
	AST_PUMP_EN: assert property (
		p_copy(lineout_pump_seq_pkg::IDX_PUMP,
			lineout_pump_seq_pkg::PUMP_EN_BIT, charge_pump_enable_o))
		else $error("pump enable wrong");
	AST_TRACK: assert property (
		p_copy(lineout_pump_seq_pkg::IDX_TRACK,
			lineout_pump_seq_pkg::TRACK_BIT, pump_level_tracking_o))
		else $error("tracking mode wrong");
	AST_SEQ_EN: assert property (
		p_copy(lineout_pump_seq_pkg::IDX_SEQ_SETUP,
			lineout_pump_seq_pkg::SEQ_EN_BIT, sequencer_enable_o))
		else $error("sequencer enable wrong");
	AST_GO_BUSY: assert property (s_go |-> ##[1:3] sequencer_busy_o)
		else $error("sequencer did not start");
endmodule
bind lineout_pump_seq_ctrl_regs lineout_pump_seq_ctrl_regs_checker #(
	.UNIT_CYCLES(UNIT_CYCLES)
) u_chk (
	.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o),
	.right_line_input_stage_en_o(right_line_input_stage_en_o),
	.right_line_mid_stage_en_o(right_line_mid_stage_en_o),
	.right_line_out_stage_en_o(right_line_out_stage_en_o),
	.charge_pump_enable_o(charge_pump_enable_o),
	.pump_level_tracking_o(pump_level_tracking_o),
	.sequencer_enable_o(sequencer_enable_o),
	.sequencer_busy_o(sequencer_busy_o)
);
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk_i;
	logic rst_b_i;
	logic [11:0] paddr_i;
	logic psel_i;
	logic penable_i;
	logic pwrite_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	wire [6:0] outs;
	int err_count;
	int comparisons;
	logic [7:0] idx [4];
	logic [15:0] mask [4];
	logic [15:0] sh [4];
	logic [31:0] rd;
	logic er;

	lineout_pump_seq_ctrl_regs #(.UNIT_CYCLES(4)) u_lineout_pump_seq_ctrl_regs (
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.right_line_input_stage_en_o(outs[6]),
		.right_line_mid_stage_en_o(outs[5]),
		.right_line_out_stage_en_o(outs[4]),
		.charge_pump_enable_o(outs[3]), .pump_level_tracking_o(outs[2]),
		.sequencer_enable_o(outs[1]), .sequencer_busy_o(outs[0])
	);

	// ****************************************
	// Expectations and reporting
	// ****************************************
	function automatic logic [31:0] exp_outs();
		return {25'h0, sh[0][0], sh[0][1], sh[0][2], sh[1][0], sh[2][0],
			sh[3][8], 1'b0};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic timeout(input string nm);
		err_count++;
		$display("Error %s expected done seen timeout", nm);
		end_of_test();
	endtask

	// ****************************************
	// Bus and sequencer helpers
	// ****************************************
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= {2'b00, a, 2'b00};
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1) timeout("pready");
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (outs[0] !== v && n < 300) begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n >= 300) timeout("busy");
	endtask
	// Pump write mid-run must be dropped, so shadow stays
	task automatic run(input logic [5:0] s);
		apb(1'b1, 8'h6f, {23'h0, 1'b1, 2'b00, s});
		wait_busy(1'b1);
		apb(1'b1, idx[1], {31'h0, ~sh[1][0]});
		wait_busy(1'b0);
		apb(1'b0, 8'h6f, 32'h0);
		chk("go bit", 32'h0, rd & 32'h100);
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		rst_b_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		err_count = 0;
		comparisons = 0;
		idx = '{lineout_pump_seq_pkg::IDX_LINEOUT,
			lineout_pump_seq_pkg::IDX_PUMP,
			lineout_pump_seq_pkg::IDX_TRACK,
			lineout_pump_seq_pkg::IDX_SEQ_SETUP};
		mask = '{16'h0007, 16'h0001, 16'h0001, 16'h011f};
		sh = '{default: 16'h0000};
		void'($urandom(32'h9320));
		repeat (3) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, idx[i], 32'h0);
			chk("reset value", 32'h0, rd);
		end
		chk("outputs", exp_outs(), {25'h0, outs});
		// First four writes are all ones, to clip the slot field
		for (int k = 0; k < 24; k++) begin
			int i;
			logic [31:0] d;
			i = (k < 4) ? k : $urandom_range(3, 0);
			d = (k < 4) ? 32'hffffffff : $urandom;
			apb(1'b1, idx[i], d);
			sh[i] = d[15:0] & mask[i];
			apb(1'b0, idx[i], 32'h0);
			chk("readback", {16'h0, sh[i]}, rd);
			chk("outputs", exp_outs(), {25'h0, outs});
		end
		apb(1'b1, 8'h5f, 32'h1);
		chk("write error", 32'h1, {31'h0, er});
		apb(1'b0, 8'h5f, 32'h0);
		chk("read error", 32'h1, {31'h0, er});
		chk("read error data", 32'h0, rd);
		// Bring-up order: input stage, 20 us gap, middle, output stage
		apb(1'b1, idx[0], 32'h1);
		repeat (20000 / lineout_pump_seq_pkg::CLK_PERIOD_NS)
			@(posedge sys_clk_i);
		apb(1'b1, idx[0], 32'h3);
		apb(1'b1, idx[0], 32'h7);
		apb(1'b1, idx[2], 32'h1);
		sh[0] = 16'h0007;
		sh[2] = 16'h0001;
		apb(1'b0, idx[2], 32'h0);
		chk("tracking", 32'h1, rd);
		chk("outputs", exp_outs(), {25'h0, outs});
		apb(1'b1, idx[0], 32'h0);
		apb(1'b1, idx[2], 32'h0);
		sh[0] = 16'h0000;
		sh[2] = 16'h0000;
		// Slot 3 sets lineout to 101 and ends; slot 4 sets tracking
		apb(1'b1, idx[3], 32'h0103);
		apb(1'b1, 8'h6d, 32'h205e);
		apb(1'b1, 8'h6e, 32'h4005);
		apb(1'b1, idx[3], 32'h0104);
		sh[3] = 16'h0104;
		apb(1'b1, 8'h6d, 32'h0068);
		apb(1'b1, 8'h6e, 32'h40ff);
		run(6'h03);
		sh[0] = 16'h0005;
		chk("outputs", exp_outs(), {25'h0, outs});
		run(6'h04);
		sh[2] = 16'h0001;
		apb(1'b0, idx[2], 32'h0);
		chk("tracking", 32'h1, rd);
		chk("outputs", exp_outs(), {25'h0, outs});
		apb(1'b0, 8'h70, 32'h0);
		chk("status", 32'h40, rd);
		// Longest delay step, so only an abort ends it within the bound
		apb(1'b1, 8'h6e, 32'h4fff);
		apb(1'b1, 8'h6f, 32'h0000_0104);
		wait_busy(1'b1);
		apb(1'b1, 8'h6f, 32'h0000_0200);
		wait_busy(1'b0);
		apb(1'b0, 8'h70, 32'h0);
		chk("status after abort", 32'h40, rd);
		chk("outputs", exp_outs(), {25'h0, outs});
		end_of_test();
	end
endmodule
`default_nettype wire
